// >>> scs_pkg.sv
package scs_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] SCS_ADDR_CONFIG   = 8'h00;  // soft reset
   localparam logic [7:0] SCS_ADDR_LINK_EN  = 8'h04;  // output link enable
   localparam logic [7:0] SCS_ADDR_CAL_EN   = 8'h08;  // calibration engine enable
   localparam logic [7:0] SCS_ADDR_FORMAT   = 8'h0c;  // output_format_select
   localparam logic [7:0] SCS_ADDR_SYNC_SEL = 8'h10;  // sync source select
   localparam logic [7:0] SCS_ADDR_CAL_CFG  = 8'h14;  // calibration settings
   localparam logic [7:0] SCS_ADDR_OVR      = 8'h18;  // overrange settings
   localparam logic [7:0] SCS_ADDR_CAL_TRIG = 8'h1c;  // calibration_trigger_bit
   localparam logic [7:0] SCS_ADDR_STATUS   = 8'h20;  // read-only status

   // ----------------------------------------------------------------
   // field layout and reset values
   // ----------------------------------------------------------------
   localparam int SCS_FORMAT_W     = 4;                // output format width
   localparam int SCS_OVR_THR_W    = 8;                // overrange threshold width
   localparam int SCS_CFG_RESET_BIT  = 0;              // soft reset bit in config
   localparam int SCS_CAL_BG_BIT   = 0;                // background calibration
   localparam int SCS_CAL_OFS_BIT  = 1;                // offset calibration
   localparam int SCS_OVERRANGE_ENABLE_BIT   = 0;                // overrange_enable
   localparam int SCS_OVR_THR_LSB  = 8;                // overrange threshold lsb
   localparam logic [3:0] SCS_FORMAT_RST = 4'h0;
   localparam logic [7:0] SCS_OVR_THR_RST = 8'h80;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int SCS_CLK_NS       = 25;               // 40 mhz clock
   localparam int SCS_CAL_TIME_NS  = 1000;             // nominal calibration run
   localparam int SCS_CAL_CYCLES   = (SCS_CAL_TIME_NS + SCS_CLK_NS - 1) / SCS_CLK_NS;
   localparam int SCS_CNT_W        = 8;

   typedef enum logic [1:0] {
      SCS_CAL_HALT,
      SCS_CAL_IDLE,
      SCS_CAL_RUN
   } scs_cal_e;

endpackage

// >>> scs_ctl_if.sv
// settings that travel from the register file to the engines
interface scs_ctl_if;
   import scs_pkg::*;
   logic                    link_en;     // output link enable
   logic                    cal_en;      // calibration engine enable
   logic [SCS_FORMAT_W-1:0] format;      // active output format
   logic                    sync_sel;    // 0 single-ended, 1 timestamp pair
   logic                    cal_bg;      // background calibration
   logic                    cal_ofs;     // offset calibration
   logic                    cal_start;   // accepted trigger pulse
   logic                    cal_busy;    // calibration running
   logic                    cal_done;    // one calibration completed (sticky)
   modport regs (output link_en, cal_en, format, sync_sel, cal_bg, cal_ofs, cal_start,
                 input cal_busy, cal_done);
   modport eng  (input link_en, cal_en, format, sync_sel, cal_bg, cal_ofs, cal_start,
                 output cal_busy, cal_done);
endinterface

// >>> scs_cal_engine.sv
module scs_cal_engine
   import scs_pkg::*;
(
   input  wire logic clk_in,     // 40 mhz clock
   input  wire logic rst_in,     // async reset, active high
   input  wire logic soft_rst_in, // software reset pulse
   scs_ctl_if.eng    ctl         // settings and status
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      scs_cal_e             st;     // calibration state
      logic [SCS_CNT_W-1:0] cnt;    // run timer
      logic                 done;   // sticky completion
   } scs_eng_s;

   scs_eng_s st_r;                  // registered state
   scs_eng_s st_nxt;                // next state

   // next-state logic
   always_comb begin
      st_nxt = st_r;
      case (st_r.st)
         SCS_CAL_HALT: begin
            if (ctl.cal_en) begin
               st_nxt.st = SCS_CAL_IDLE;
            end
         end
         SCS_CAL_IDLE: begin
            if (!ctl.cal_en) begin
               st_nxt.st = SCS_CAL_HALT;
            end else if (ctl.cal_start) begin
               st_nxt.st   = SCS_CAL_RUN;
               st_nxt.cnt  = SCS_CNT_W'(SCS_CAL_CYCLES - 1);
               st_nxt.done = 1'b0;
            end
         end
         SCS_CAL_RUN: begin
            if (!ctl.cal_en) begin
               st_nxt.st = SCS_CAL_HALT;           // halting aborts a run
            end else if (st_r.cnt == '0) begin
               st_nxt.st   = SCS_CAL_IDLE;
               st_nxt.done = 1'b1;
            end else begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end
         end
         default: st_nxt.st = SCS_CAL_HALT;
      endcase
      if (soft_rst_in) begin
         st_nxt = '{st: SCS_CAL_HALT, cnt: '0, done: 1'b0};
      end
   end

   // state register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '{st: SCS_CAL_HALT, cnt: '0, done: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ctl.cal_busy = (st_r.st == SCS_CAL_RUN);
   assign ctl.cal_done = st_r.done;

endmodule

// >>> scs_link_engine.sv
module scs_link_engine
   import scs_pkg::*;
(
   input  wire logic                    clk_in,      // 40 mhz clock
   input  wire logic                    rst_in,      // async reset, active high
   input  wire logic                    soft_rst_in, // software reset pulse
   input  wire logic                    sync_se_in,  // single_ended_sync_input
   input  wire logic                    sync_ts_in,  // timestamp_diff_input (received)
   scs_ctl_if.eng                       ctl,         // settings
   output logic                         active_out,  // link running
   output logic [SCS_FORMAT_W-1:0]      format_out,  // format in use
   output logic                         strobe_out   // strobe / pattern request pulse
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                    active;   // link state machine running
      logic [SCS_FORMAT_W-1:0] format;   // format latched at enable
      logic                    sync_d;   // previous sync level
      logic                    strobe;   // strobe request
   } scs_lnk_s;

   scs_lnk_s st_r;   // registered state
   scs_lnk_s st_nxt; // next state
   logic     sync_lv; // selected sync level

   // pick the sync source
   always_comb begin
      sync_lv = ctl.sync_sel ? sync_ts_in : sync_se_in;
   end

   // format is latched only while halted so a running link sees a change only on a soft reset
   always_comb begin
      st_nxt        = st_r;
      st_nxt.active = ctl.link_en;
      if (!st_r.active) begin
         st_nxt.format = ctl.format;
      end
      st_nxt.sync_d = sync_lv;
      st_nxt.strobe = st_r.active && sync_lv && !st_r.sync_d;
      if (soft_rst_in) begin
         st_nxt = '{active: 1'b0, format: SCS_FORMAT_RST, sync_d: 1'b0, strobe: 1'b0};
      end
   end

   // state register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '{active: 1'b0, format: SCS_FORMAT_RST, sync_d: 1'b0, strobe: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign active_out = st_r.active;
   assign format_out = st_r.format;
   assign strobe_out = st_r.strobe;

endmodule

// >>> scs_startup_seq.sv
// Function
// - link enable zero halts link, allows changes
// - calibration enable zero halts calibration engine
// - sync source selects single-ended or timestamp
// - calibration enable one starts calibration engine
// - link enable one restarts output link
// - selected sync edge sends strobe pattern
// - trigger zero then one starts calibration
//
// The address map and the plain strobed port were chosen for this implementation.
module scs_startup_seq
   import scs_pkg::*;
(
   input  wire logic                    clk_in,         // 40 mhz clock
   input  wire logic                    rst_in,         // async reset, active high
   input  wire logic [7:0]              addr_in,        // register byte address
   input  wire logic [31:0]             wdata_in,       // write data
   input  wire logic                    wr_in,          // write strobe
   input  wire logic                    rd_in,          // read strobe
   output logic [31:0]                  rdata_out,      // read data, cycle after rd
   input  wire logic                    sync_se_in,     // single_ended_sync_input
   input  wire logic                    sync_ts_in,     // timestamp_diff_input
   output logic                         link_active_out, // output link running
   output logic [SCS_FORMAT_W-1:0]      format_out,     // format in use
   output logic                         strobe_out,     // strobe request pulse
   output logic                         cal_busy_out,   // calibration running
   output logic                         overrange_enable_out,     // overrange_enable
   output logic [SCS_OVR_THR_W-1:0]     ovr_thr_out     // overrange threshold
);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                     link_en;   // output link enable
      logic                     cal_en;    // calibration engine enable
      logic [SCS_FORMAT_W-1:0]  format;    // output_format_select
      logic                     sync_sel;  // sync source
      logic                     cal_bg;    // background mode
      logic                     cal_ofs;   // offset calibration
      logic                     overrange_enable;    // overrange_enable
      logic [SCS_OVR_THR_W-1:0] ovr_thr;   // overrange threshold
      logic                     trig;      // calibration_trigger_bit
      logic                     start;     // accepted trigger pulse
      logic                     soft_rst;  // software reset pulse
      logic [31:0]              rdata;     // read data
   } scs_reg_s;

   scs_reg_s st_r;    // registered state
   scs_reg_s st_nxt;  // next state

   scs_ctl_if ctl (); // settings bundle

   localparam scs_reg_s SCS_REG_RST = '{
      link_en: 1'b0, cal_en: 1'b0, format: SCS_FORMAT_RST, sync_sel: 1'b0,
      cal_bg: 1'b0, cal_ofs: 1'b0, overrange_enable: 1'b0, ovr_thr: SCS_OVR_THR_RST,
      trig: 1'b0, start: 1'b0, soft_rst: 1'b0, rdata: 32'h0000_0000};

   // ----------------------------------------------------------------
   // register write / read
   // ----------------------------------------------------------------
   // link settings are held while link enable is set, calibration ones while calibration enable is set
   always_comb begin
      st_nxt          = st_r;
      st_nxt.start    = 1'b0;
      st_nxt.soft_rst = 1'b0;
      st_nxt.rdata    = 32'h0000_0000;
      if (wr_in) begin
         case (addr_in)
            SCS_ADDR_CONFIG: begin
               st_nxt.soft_rst = wdata_in[SCS_CFG_RESET_BIT];
            end
            SCS_ADDR_LINK_EN: begin
               st_nxt.link_en = wdata_in[0];
            end
            SCS_ADDR_CAL_EN: begin
               st_nxt.cal_en = wdata_in[0];
            end
            SCS_ADDR_FORMAT: begin
               if (!st_r.link_en) begin
                  st_nxt.format = wdata_in[SCS_FORMAT_W-1:0];
               end
            end
            SCS_ADDR_SYNC_SEL: begin
               if (!st_r.link_en) begin
                  st_nxt.sync_sel = wdata_in[0];
               end
            end
            SCS_ADDR_CAL_CFG: begin
               if (!st_r.cal_en) begin
                  st_nxt.cal_bg  = wdata_in[SCS_CAL_BG_BIT];
                  st_nxt.cal_ofs = wdata_in[SCS_CAL_OFS_BIT];
               end
            end
            SCS_ADDR_OVR: begin
               st_nxt.overrange_enable  = wdata_in[SCS_OVERRANGE_ENABLE_BIT];
               st_nxt.ovr_thr = wdata_in[SCS_OVR_THR_LSB +: SCS_OVR_THR_W];
            end
            SCS_ADDR_CAL_TRIG: begin
               st_nxt.trig = wdata_in[0];
               // rising edge while engine enabled only; the engine acts on it only when idle
               st_nxt.start = wdata_in[0] && !st_r.trig && st_r.cal_en;
            end
            default: st_nxt.soft_rst = 1'b0;                     // unmapped: ignored
         endcase
      end
      if (rd_in) begin
         case (addr_in)
            SCS_ADDR_LINK_EN:  st_nxt.rdata = {31'h0, st_r.link_en};
            SCS_ADDR_CAL_EN:   st_nxt.rdata = {31'h0, st_r.cal_en};
            SCS_ADDR_FORMAT:   st_nxt.rdata = {28'h0, st_r.format};
            SCS_ADDR_SYNC_SEL: st_nxt.rdata = {31'h0, st_r.sync_sel};
            SCS_ADDR_CAL_CFG:  st_nxt.rdata = {30'h0, st_r.cal_ofs, st_r.cal_bg};
            SCS_ADDR_OVR:      st_nxt.rdata = {16'h0, st_r.ovr_thr, 7'h0, st_r.overrange_enable};
            SCS_ADDR_CAL_TRIG: st_nxt.rdata = {31'h0, st_r.trig};
            SCS_ADDR_STATUS:   st_nxt.rdata = {29'h0, ctl.cal_done, ctl.cal_busy,
                                               link_active_out};
            default:           st_nxt.rdata = 32'h0000_0000;     // config reads zero
         endcase
      end
      // software reset returns all settings to defaults next cycle
      if (st_r.soft_rst) begin
         st_nxt = SCS_REG_RST;
      end
   end

   // state register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= SCS_REG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // engines
   // ----------------------------------------------------------------
   assign ctl.link_en   = st_r.link_en;
   assign ctl.cal_en    = st_r.cal_en;
   assign ctl.format    = st_r.format;
   assign ctl.sync_sel  = st_r.sync_sel;
   assign ctl.cal_bg    = st_r.cal_bg;
   assign ctl.cal_ofs   = st_r.cal_ofs;
   assign ctl.cal_start = st_r.start;

   scs_cal_engine u_cal (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .soft_rst_in (st_r.soft_rst),
      .ctl         (ctl.eng)
   );

   scs_link_engine u_link (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .soft_rst_in (st_r.soft_rst),
      .sync_se_in  (sync_se_in),
      .sync_ts_in  (sync_ts_in),
      .ctl         (ctl.eng),
      .active_out  (link_active_out),
      .format_out  (format_out),
      .strobe_out  (strobe_out)
   );

   assign rdata_out    = st_r.rdata;
   assign cal_busy_out = ctl.cal_busy;
   assign overrange_enable_out   = st_r.overrange_enable;
   assign ovr_thr_out  = st_r.ovr_thr;

endmodule

// >>> scs_startup_seq_assertions.sv
module scs_startup_seq_assertions
   import scs_pkg::*;
(
   input wire logic                     clk_in,          // clock
   input wire logic                     rst_in,          // async reset
   input wire logic [7:0]               addr_in,         // address
   input wire logic [31:0]              wdata_in,        // write data
   input wire logic                     wr_in,           // write strobe
   input wire logic                     rd_in,           // read strobe
   input wire logic [31:0]              rdata_out,       // read data
   input wire logic                     sync_se_in,      // sync level
   input wire logic                     sync_ts_in,      // timestamp level
   input wire logic                     link_active_out, // link running
   input wire logic [SCS_FORMAT_W-1:0]  format_out,      // format in use
   input wire logic                     strobe_out,      // strobe pulse
   input wire logic                     cal_busy_out,    // cal running
   input wire logic                     overrange_enable_out,      // overrange_enable
   input wire logic [SCS_OVR_THR_W-1:0] ovr_thr_out      // threshold
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ----------------------------------------
   // shadow of enable and trigger bits
   // ----------------------------------------
   logic [7:0] busy_cnt_r;  // cycles busy so far
   logic       cal_en_r;    // last cal enable written
   logic       trig_r;      // last trigger bit written
   logic       soft_w;      // soft reset write now
   assign soft_w = wr_in && addr_in == SCS_ADDR_CONFIG && wdata_in[0];
   // shadows follow the writes; a soft reset clears them like the device
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_cnt_r <= 8'h00;
         cal_en_r   <= 1'b0;
         trig_r     <= 1'b0;
      end else begin
         busy_cnt_r <= cal_busy_out ? busy_cnt_r + 8'h01 : 8'h00;
         if (soft_w) begin
            cal_en_r <= 1'b0;
            trig_r   <= 1'b0;
         end else if (wr_in && addr_in == SCS_ADDR_CAL_EN) begin
            cal_en_r <= wdata_in[0];
         end else if (wr_in && addr_in == SCS_ADDR_CAL_TRIG) begin
            trig_r <= wdata_in[0];
         end
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   AST_LINK_FOLLOW: assert property (wr_in && addr_in == SCS_ADDR_LINK_EN |-> ##2
      link_active_out == $past(wdata_in[0], 2)) else $error("link state not following enable");
   // a soft reset returns the format to default even on a running link
   AST_FORMAT_HOLD: assert property ($past(link_active_out, 2) && $past(link_active_out) &&
      !$past(soft_w, 2) |-> $stable(format_out)) else $error("format changed while link running");
   AST_STROBE_CAUSE: assert property (strobe_out |-> $past(link_active_out) &&
      ($past(sync_se_in) && !$past(sync_se_in, 2) || $past(sync_ts_in) && !$past(sync_ts_in, 2)))
      else $error("strobe without sync edge");
   AST_BUSY_MAX: assert property (cal_busy_out |-> busy_cnt_r < 8'(SCS_CAL_CYCLES))
      else $error("calibration too long");
   // an abort by enable or soft reset ends a run early on purpose
   AST_BUSY_LEN: assert property ($fell(cal_busy_out) && cal_en_r |-> busy_cnt_r == 8'(SCS_CAL_CYCLES))
      else $error("calibration too short");
   AST_TRIG_START: assert property (wr_in && addr_in == SCS_ADDR_CAL_TRIG && wdata_in[0] && !trig_r
      && cal_en_r && !cal_busy_out |-> ##2 cal_busy_out) else $error("trigger did not start");
   AST_TRIG_IGNORE: assert property (wr_in && addr_in == SCS_ADDR_CAL_TRIG && !cal_busy_out &&
      (trig_r || !cal_en_r || !wdata_in[0]) |-> ##2 !cal_busy_out) else $error("bad trigger started");
   AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 32'h0) else $error("read data outside slot");
   AST_SOFT_RST: assert property (soft_w |-> ##3 !link_active_out && !cal_busy_out && !overrange_enable_out
      && ovr_thr_out == SCS_OVR_THR_RST) else $error("soft reset incomplete");
   AST_OVR_WR: assert property (wr_in && addr_in == SCS_ADDR_OVR |-> ##1 overrange_enable_out == $past(wdata_in[0])
      && ovr_thr_out == $past(wdata_in[15:8])) else $error("overrange settings wrong");
   cover property (strobe_out);
   cover property ($fell(cal_busy_out));
   cover property (soft_w);
endmodule

bind scs_startup_seq scs_startup_seq_assertions u_scs_startup_seq_assertions (
   .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
   .rd_in(rd_in), .rdata_out(rdata_out), .sync_se_in(sync_se_in), .sync_ts_in(sync_ts_in),
   .link_active_out(link_active_out), .format_out(format_out), .strobe_out(strobe_out),
   .cal_busy_out(cal_busy_out), .overrange_enable_out(overrange_enable_out), .ovr_thr_out(ovr_thr_out));

// >>> scs_host_model.sv
module scs_host_model
   import scs_pkg::*;
(
   input  wire logic        clk_in,    // bus clock
   output logic [7:0]       addr_out,  // register address
   output logic [31:0]      wdata_out, // write data
   output logic             wr_out,    // write strobe
   output logic             rd_out     // read strobe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      addr_out  = 8'h00;
      wdata_out = 32'h0;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
   end
   // one-cycle write; data inverted afterwards so stale data never matches
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'b1;
      @(posedge clk_in);
      wr_out    <= 1'b0;
      wdata_out <= ~d;
   endtask
   // one-cycle read; the bench watches the data slot
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge clk_in);
      rd_out   <= 1'b0;
   endtask
   // full bring-up order: halt both engines, configure, restart
   task automatic startup(input logic [3:0] f, input logic s, input logic [15:0] o);
      wr_reg(SCS_ADDR_LINK_EN, 32'h0);
      wr_reg(SCS_ADDR_CAL_EN, 32'h0);
      wr_reg(SCS_ADDR_FORMAT, {28'h0, f});
      wr_reg(SCS_ADDR_SYNC_SEL, {31'h0, s});
      wr_reg(SCS_ADDR_CAL_CFG, 32'h3);
      wr_reg(SCS_ADDR_CAL_EN, 32'h1);
      wr_reg(SCS_ADDR_OVR, {16'h0, o});
      wr_reg(SCS_ADDR_LINK_EN, 32'h1);
   endtask
   // zero then one on the trigger bit
   task automatic trigger();
      wr_reg(SCS_ADDR_CAL_TRIG, 32'h0);
      wr_reg(SCS_ADDR_CAL_TRIG, 32'h1);
   endtask
endmodule

// >>> scs_startup_seq_bench.sv
module scs_startup_seq_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import scs_pkg::*;
   logic clk_in = 1'b0, rst_in = 1'b1, sync_se = 1'b0, sync_ts = 1'b0, wr, rd, link, strobe, busy, overrange_enable;
   logic [7:0]  addr, ovr_thr, thr;
   logic [31:0] wdata, rdata;
   logic [3:0]  format, fmt;
   logic [31:0] rd_q[$];     // expected read data, oldest first
   logic        strobe_q[$]; // one note per expected strobe
   logic        rd_seen_r = 1'b0;
   int          errors = 0, n_checks = 0, cycles = 0, n;
   always #12.5 clk_in = ~clk_in;
   scs_host_model u_scs_host_model (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
      .rd_out(rd));
   scs_startup_seq u_scs_startup_seq (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sync_se_in(sync_se), .sync_ts_in(sync_ts),
      .link_active_out(link), .format_out(format), .strobe_out(strobe), .cal_busy_out(busy),
      .overrange_enable_out(overrange_enable), .ovr_thr_out(ovr_thr));
   // ----------------------------------------
   // compare and report
   // ----------------------------------------
   task automatic miss(input string m);
      errors++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic check_rd(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) miss($sformatf("read %h expected %h", g, e));
   endtask
   task automatic check_out(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) miss($sformatf("output %h expected %h", g, e));
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // monitor: read slot is the cycle after the strobe, strobes pop notes
   always @(posedge clk_in) begin
      if (rd_seen_r) begin
         if (rd_q.size() == 0) miss("read with no note");
         else check_rd(rdata, rd_q.pop_front());
      end
      if (strobe === 1'b1) begin
         n_checks++;
         if (strobe_q.size() == 0) miss("unexpected strobe");
         else void'(strobe_q.pop_front());
      end
      rd_seen_r <= rd;
      cycles++;
      if (cycles == 3000) begin
         miss("timeout");
         complete_run();
      end
   end
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      u_scs_host_model.rd_reg(a);
   endtask
   // hold one sync line high for three cycles, then rest
   task automatic pulse(input logic ts, input logic hit);
      if (hit) strobe_q.push_back(1'b1);
      @(posedge clk_in);
      if (ts) sync_ts <= 1'b1;
      else sync_se <= 1'b1;
      repeat (3) @(posedge clk_in);
      sync_ts <= 1'b0;
      sync_se <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'hc52a));
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      #1;
      check_out(32'(ovr_thr), 32'h80);
      check_out(32'(format), 32'h0);
      rd_chk(SCS_ADDR_STATUS, 32'h0);
      rd_chk(SCS_ADDR_CONFIG, 32'h0);
      rd_chk(8'h40, 32'h0);                     // unmapped reads zero
      $display("test reset done");
      fmt = 4'($urandom);
      thr = 8'($urandom);
      u_scs_host_model.startup(fmt, 1'b0, {thr, 8'h01});
      repeat (2) @(posedge clk_in);
      #1;
      check_out(32'(link), 32'h1);
      check_out(32'(format), 32'(fmt));
      check_out(32'({ovr_thr, overrange_enable}), 32'({thr, 1'b1}));
      u_scs_host_model.wr_reg(SCS_ADDR_FORMAT, 32'(~fmt));
      repeat (2) @(posedge clk_in);
      #1;
      check_out(32'(format), 32'(fmt));
      rd_chk(SCS_ADDR_FORMAT, 32'(fmt));
      u_scs_host_model.wr_reg(SCS_ADDR_CAL_CFG, 32'h0);
      rd_chk(SCS_ADDR_CAL_CFG, 32'h3);
      $display("test startup done");
      for (int s = 0; s < 2; s++) begin
         u_scs_host_model.startup(4'($urandom), s[0], 16'h8000);
         repeat (2) @(posedge clk_in);
         pulse(~s[0], 1'b0);
         pulse(s[0], 1'b1);
      end
      check_out(32'(strobe_q.size()), 32'h0);
      $display("test sync done");
      u_scs_host_model.trigger();
      repeat (2) @(posedge clk_in);
      #1;
      check_out(32'(busy), 32'h1);
      n = 1;                                    // busy rose one cycle before the first look
      while (busy === 1'b1 && n < 100) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      check_out(32'(n), 32'(SCS_CAL_CYCLES));
      rd_chk(SCS_ADDR_STATUS, 32'h5);
      u_scs_host_model.wr_reg(SCS_ADDR_CAL_TRIG, 32'h1);
      repeat (3) @(posedge clk_in);
      #1;
      check_out(32'(busy), 32'h0);
      u_scs_host_model.wr_reg(SCS_ADDR_CAL_EN, 32'h0);
      u_scs_host_model.trigger();
      repeat (3) @(posedge clk_in);
      #1;
      check_out(32'(busy), 32'h0);
      rd_chk(SCS_ADDR_STATUS, 32'h5);
      $display("test calibration done");
      u_scs_host_model.wr_reg(SCS_ADDR_CONFIG, 32'h1);
      repeat (4) @(posedge clk_in);
      #1;
      check_out(32'({link, busy, overrange_enable, ovr_thr}), 32'(11'h080));
      rd_chk(SCS_ADDR_STATUS, 32'h0);
      repeat (3) @(posedge clk_in);
      check_out(32'(rd_q.size()), 32'h0);
      $display("test soft reset done");
      complete_run();
   end
endmodule
